/* File: include/atr_pkg.sv */
package atr_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_ASTAT = 8'h14;

  // Buffered register slots; the index is also the busy bit in async_status
  localparam int NUM_BUF = 5;
  localparam int BUF_CTRL_B = 0;
  localparam int BUF_CTRL_A = 1;
  localparam int BUF_CMP_B = 2;
  localparam int BUF_CMP_A = 3;
  localparam int BUF_COUNT = 4;

  // Field positions
  localparam int FOC_A_BIT = 7;
  localparam int FOC_B_BIT = 6;
  localparam int WGM2_BIT = 3;
  localparam int EXT_CLK_BIT = 6;
  localparam int ASYNC_SEL_BIT = 5;
  localparam logic [7:0] CTRL_B_WR_MASK = 8'hCF;
  localparam logic [7:0] CTRL_B_RD_MASK = 8'h0F;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [9:0] PRESC_RST = 10'h000;

  // Prescaler tap masks, one per clock select code
  localparam logic [9:0] PSC_DIV1 = 10'h000;
  localparam logic [9:0] PSC_DIV8 = 10'h007;
  localparam logic [9:0] PSC_DIV32 = 10'h01F;
  localparam logic [9:0] PSC_DIV64 = 10'h03F;
  localparam logic [9:0] PSC_DIV128 = 10'h07F;
  localparam logic [9:0] PSC_DIV256 = 10'h0FF;
  localparam logic [9:0] PSC_DIV1024 = 10'h3FF;

  // Timing counts
  localparam logic [1:0] ASYNC_LOAD_EDGES = 2'h2;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // Compare output modes
  typedef enum logic [1:0] {
    OM_OFF = 2'b00,
    OM_TOGGLE = 2'b01,
    OM_CLEAR = 2'b10,
    OM_SET = 2'b11
  } atr_out_mode_e;

  typedef struct packed {
    logic [1:0] out_mode_chan_a;
    logic [1:0] out_mode_chan_b;
    logic [1:0] rsvd;
    logic [1:0] wave_mode_low;
  } atr_ctrl_a_s;

  typedef struct packed {
    logic force_cmp_chan_a;
    logic force_cmp_chan_b;
    logic [1:0] rsvd;
    logic wave_mode_high_bit;
    logic [2:0] clock_select_field;
  } atr_ctrl_b_s;

  // Flag-set events: compare a, compare b, overflow
  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic ovf;
  } atr_events_s;
endpackage : atr_pkg

/* File: rtl/atr_buf_reg.sv */
`timescale 1ns/100ps
// One buffered register: temporary copy, destination and update-busy flag
module atr_buf_reg import atr_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic async_mode,
  input wire logic osc_edge,
  output logic [WIDTH-1:0] temp_q,
  output logic [WIDTH-1:0] dest_q,
  output logic busy_q,
  output logic load_pulse,
  output logic [WIDTH-1:0] load_data
);
  logic [WIDTH-1:0] temp_nxt;
  logic [WIDTH-1:0] dest_nxt;
  logic busy_nxt;
  logic [1:0] edges_r;
  logic [1:0] edges_nxt;
  logic async_done;

  // Transfer completes on the second oscillator rising edge after the write
  assign async_done = busy_q && osc_edge && (edges_r == ASYNC_LOAD_EDGES - 2'h1);
  assign load_pulse = (wr_en && !async_mode) || (async_done && !wr_en);
  assign load_data = wr_en ? wdata : temp_q;

  // Next values; a new write re-arms the transfer and wins over completion
  always_comb begin
    temp_nxt = temp_q;
    dest_nxt = dest_q;
    busy_nxt = busy_q;
    edges_nxt = edges_r;
    if (wr_en) begin
      temp_nxt = wdata;
      edges_nxt = 2'h0;
      if (async_mode) begin
        busy_nxt = 1'b1;
      end else begin
        dest_nxt = wdata;
        busy_nxt = 1'b0;
      end
    end else if (async_done) begin
      dest_nxt = temp_q;
      busy_nxt = 1'b0;
      edges_nxt = 2'h0;
    end else if (busy_q && osc_edge) begin
      edges_nxt = edges_r + 2'h1;
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= '0;
      dest_q <= '0;
      busy_q <= 1'b0;
      edges_r <= 2'h0;
    end else if (clk_en) begin
      temp_q <= temp_nxt;
      dest_q <= dest_nxt;
      busy_q <= busy_nxt;
      edges_r <= edges_nxt;
    end
  end
endmodule : atr_buf_reg

/* File: rtl/atr_timer.sv */
`timescale 1ns/100ps
// Overview of operation
// - Force-compare write in non-PWM mode applies a match to that channel's output now.
// - A forced compare raises no event and never clears the counter.
// - Force-compare bits are strobes and always read back as zero.
// - Control B bits 5 and 4 are reserved and read as zero.
// - Clock select 000 stops; 001..111 divide source by 1,8,32,64,128,256,1024.
// - Counter register gives direct read and write access to the count.
// - A counter write suppresses compare match on the next timer tick.
// - Both compare registers are compared continuously with the count.
// - External-clock bit with async enables input buffer; crystal runs only when clear.
// - Async select zero clocks from I/O clock, one from the oscillator pin.
// - Async writes set the register's busy flag; cleared when destination loads.
// - Counter reads the live value; other buffered registers read temporary copy.
// - Async writes reach the destination after two oscillator rising edges.
// - Async events reach the processor three cycles after the timer tick.
module atr_timer import atr_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_input_pin,
  output logic wave_out_chan_a,
  output logic wave_out_chan_b,
  output logic cmp_a_event,
  output logic cmp_b_event,
  output logic ovf_event,
  output logic osc_buf_enable,
  output logic xtal_osc_run
);
  // Bus side state
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic ext_clk_r;
  logic ext_clk_nxt;
  logic async_sel_r;
  logic async_sel_nxt;
  logic osc_buf_nxt;
  logic xtal_run_nxt;
  logic access;
  logic wr_fire;
  logic hit;
  logic [7:0] rd_byte;
  logic [NUM_BUF-1:0] buf_wr;
  logic [7:0] buf_wdata [NUM_BUF];
  logic [7:0] buf_temp [NUM_BUF];
  logic [7:0] buf_dest [NUM_BUF];
  logic [7:0] buf_ldat [NUM_BUF];
  logic [NUM_BUF-1:0] buf_busy;
  logic [NUM_BUF-1:0] buf_load;

  // Timer side state
  logic osc_s_r;
  logic osc_d_r;
  logic osc_edge;
  logic [9:0] presc_r;
  logic [9:0] presc_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic down_r;
  logic down_nxt;
  logic block_r;
  logic block_nxt;
  logic wa_nxt;
  logic wb_nxt;
  atr_events_s ev;
  atr_events_s pipe0_r;
  atr_events_s pipe1_r;
  atr_events_s evt_nxt;
  atr_ctrl_a_s ctrl_a;
  atr_ctrl_b_s ctrl_b;
  logic [2:0] mode;
  logic pwm;
  logic phase;
  logic [7:0] top;
  logic src_tick;
  logic tick;
  logic [9:0] tap;
  logic match_a;
  logic match_b;
  logic force_a;
  logic force_b;
  logic at_top;

  // Address decode and read mux
  assign access = psel && penable;
  assign wr_fire = access && pready && pwrite;
  always_comb begin
    hit = 1'b1;
    rd_byte = REG_RST;
    case (paddr)
      OFS_CTRL_A: rd_byte = buf_temp[BUF_CTRL_A];
      OFS_CTRL_B: rd_byte = buf_temp[BUF_CTRL_B] & CTRL_B_RD_MASK;
      OFS_COUNT: rd_byte = cnt_r;
      OFS_CMP_A: rd_byte = buf_temp[BUF_CMP_A];
      OFS_CMP_B: rd_byte = buf_temp[BUF_CMP_B];
      OFS_ASTAT: rd_byte = {1'b0, ext_clk_r, async_sel_r, buf_busy};
      default: hit = 1'b0;
    endcase
  end

  // Write strobes for the five buffered registers
  always_comb begin
    buf_wr = '0;
    buf_wr[BUF_CTRL_A] = wr_fire && (paddr == OFS_CTRL_A);
    buf_wr[BUF_CTRL_B] = wr_fire && (paddr == OFS_CTRL_B);
    buf_wr[BUF_COUNT] = wr_fire && (paddr == OFS_COUNT);
    buf_wr[BUF_CMP_A] = wr_fire && (paddr == OFS_CMP_A);
    buf_wr[BUF_CMP_B] = wr_fire && (paddr == OFS_CMP_B);
    for (int i = 0; i < NUM_BUF; i++) begin
      buf_wdata[i] = pwdata[7:0];
    end
    buf_wdata[BUF_CTRL_B] = pwdata[7:0] & CTRL_B_WR_MASK;
  end

  // Bus answer: one wait state, data and error stand with pready
  always_comb begin
    pready_nxt = access && !pready;
    prdata_nxt = prdata;
    pslverr_nxt = access && !pready && !hit;
    ext_clk_nxt = ext_clk_r;
    async_sel_nxt = async_sel_r;
    osc_buf_nxt = ext_clk_r && async_sel_r;
    xtal_run_nxt = !ext_clk_r;
    if (access && !pready) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    if (wr_fire && (paddr == OFS_ASTAT)) begin
      ext_clk_nxt = pwdata[EXT_CLK_BIT];
      async_sel_nxt = pwdata[ASYNC_SEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ext_clk_r <= 1'b0;
      async_sel_r <= 1'b0;
      osc_buf_enable <= 1'b0;
      xtal_osc_run <= 1'b1;
    end else if (clk_en) begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      ext_clk_r <= ext_clk_nxt;
      async_sel_r <= async_sel_nxt;
      osc_buf_enable <= osc_buf_nxt;
      xtal_osc_run <= xtal_run_nxt;
    end
  end

  // Five temporary/destination pairs
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++) begin : g_buf
      atr_buf_reg #(.WIDTH(8)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(buf_wr[g]),
        .wdata(buf_wdata[g]),
        .async_mode(async_sel_r),
        .osc_edge(osc_edge),
        .temp_q(buf_temp[g]),
        .dest_q(buf_dest[g]),
        .busy_q(buf_busy[g]),
        .load_pulse(buf_load[g]),
        .load_data(buf_ldat[g])
      );
    end
  endgenerate

  // Mode decode from the destination copies
  assign ctrl_a = atr_ctrl_a_s'(buf_dest[BUF_CTRL_A]);
  assign ctrl_b = atr_ctrl_b_s'(buf_dest[BUF_CTRL_B]);
  assign mode = {ctrl_b.wave_mode_high_bit, ctrl_a.wave_mode_low};
  assign pwm = mode[0];
  assign phase = (mode == 3'h1) || (mode == 3'h5);
  assign top = ((mode == 3'h2) || (mode == 3'h5) || (mode == 3'h7)) ? buf_dest[BUF_CMP_A] : CNT_MAX;

  // Source clock: pin sampled once, rising edge used as a tick in async mode
  assign osc_edge = osc_s_r && !osc_d_r;
  assign src_tick = async_sel_r ? osc_edge : 1'b1;

  // Prescaler tap per clock select code
  always_comb begin
    case (ctrl_b.clock_select_field)
      3'h1: tap = PSC_DIV1;
      3'h2: tap = PSC_DIV8;
      3'h3: tap = PSC_DIV32;
      3'h4: tap = PSC_DIV64;
      3'h5: tap = PSC_DIV128;
      3'h6: tap = PSC_DIV256;
      3'h7: tap = PSC_DIV1024;
      default: tap = PSC_DIV1;
    endcase
  end
  assign tick = src_tick && (ctrl_b.clock_select_field != 3'h0) && ((presc_r & tap) == tap);

  // Continuous compare, blocked for one tick after a counter write
  assign match_a = tick && !block_r && (cnt_r == buf_dest[BUF_CMP_A]);
  assign match_b = tick && !block_r && (cnt_r == buf_dest[BUF_CMP_B]);
  assign at_top = tick && (cnt_r == top);
  assign force_a = buf_load[BUF_CTRL_B] && buf_ldat[BUF_CTRL_B][FOC_A_BIT] && !pwm;
  assign force_b = buf_load[BUF_CTRL_B] && buf_ldat[BUF_CTRL_B][FOC_B_BIT] && !pwm;

  // Output pin update for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] om, input logic hit_m,
                                     input logic hit_top, input logic frc, input logic is_a);
    logic v;
    v = cur;
    if (!pwm) begin
      if (hit_m || frc) begin
        case (atr_out_mode_e'(om))
          OM_TOGGLE: v = !cur;
          OM_CLEAR: v = 1'b0;
          OM_SET: v = 1'b1;
          default: v = cur;
        endcase
      end
    end else if (om == OM_TOGGLE) begin
      if (is_a && ctrl_b.wave_mode_high_bit && hit_m) begin
        v = !cur;
      end
    end else if (om != OM_OFF) begin
      if (phase) begin
        if (hit_m) begin
          v = (om == OM_SET) ^ down_r;
        end
      end else if (hit_m) begin
        v = (om == OM_SET);
      end else if (hit_top) begin
        v = (om == OM_CLEAR);
      end
    end
    return v;
  endfunction

  // Counter, direction, compare block and pins
  always_comb begin
    presc_nxt = src_tick ? presc_r + 10'h001 : presc_r;
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    block_nxt = block_r;
    ev = '0;
    if (buf_load[BUF_COUNT]) begin
      cnt_nxt = buf_ldat[BUF_COUNT];
      block_nxt = 1'b1;
    end else if (tick) begin
      block_nxt = 1'b0;
      if (phase) begin
        if (!down_r && (cnt_r == top)) begin
          down_nxt = 1'b1;
          cnt_nxt = cnt_r - 8'h01;
        end else if (down_r && (cnt_r == CNT_BOTTOM)) begin
          down_nxt = 1'b0;
          cnt_nxt = cnt_r + 8'h01;
          ev.ovf = 1'b1;
        end else begin
          cnt_nxt = down_r ? cnt_r - 8'h01 : cnt_r + 8'h01;
        end
      end else begin
        down_nxt = 1'b0;
        cnt_nxt = (cnt_r == top) ? CNT_BOTTOM : cnt_r + 8'h01;
        ev.ovf = (cnt_r == CNT_MAX);
      end
    end
    ev.cmp_a = match_a;
    ev.cmp_b = match_b;
    wa_nxt = wave_next(wave_out_chan_a, ctrl_a.out_mode_chan_a, match_a, at_top, force_a, 1'b1);
    wb_nxt = wave_next(wave_out_chan_b, ctrl_a.out_mode_chan_b, match_b, at_top, force_b, 1'b0);
    // Async events cross via two extra stages, sync ones go out next cycle
    evt_nxt = async_sel_r ? pipe1_r : ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s_r <= 1'b0;
      osc_d_r <= 1'b0;
      presc_r <= PRESC_RST;
      cnt_r <= REG_RST;
      down_r <= 1'b0;
      block_r <= 1'b0;
      wave_out_chan_a <= 1'b0;
      wave_out_chan_b <= 1'b0;
      pipe0_r <= '0;
      pipe1_r <= '0;
      {cmp_a_event, cmp_b_event, ovf_event} <= 3'h0;
    end else if (clk_en) begin
      osc_s_r <= osc_input_pin;
      osc_d_r <= osc_s_r;
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
      block_r <= block_nxt;
      wave_out_chan_a <= wa_nxt;
      wave_out_chan_b <= wb_nxt;
      pipe0_r <= ev;
      pipe1_r <= pipe0_r;
      {cmp_a_event, cmp_b_event, ovf_event} <= evt_nxt;
    end
  end

  // Checks on the block's own behaviour
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  chk_force_read_zero: assert property (pready && !pwrite && (paddr == OFS_CTRL_B) |-> prdata[7:6] == 2'h0)
    else $error("force bits read nonzero");
  chk_rsvd_read_zero: assert property (pready && !pwrite && (paddr == OFS_CTRL_B) |-> prdata[5:4] == 2'h0)
    else $error("reserved bits read nonzero");
  chk_status_bit7: assert property (pready && !pwrite && (paddr == OFS_ASTAT) |-> !prdata[7])
    else $error("status bit 7 nonzero");
  chk_sync_busy_zero: assert property (!async_sel_r && $stable(async_sel_r) && $past(buf_busy) == '0 |-> buf_busy == '0)
    else $error("busy set in sync mode");
  chk_async_busy_set: assert property (async_sel_r && buf_wr[BUF_CMP_A] |=> buf_busy[BUF_CMP_A])
    else $error("busy not set on async write");
  chk_stop_holds: assert property ((ctrl_b.clock_select_field == 3'h0) && !buf_load[BUF_COUNT] |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  chk_write_blocks: assert property (buf_load[BUF_COUNT] |=> !match_a && !match_b)
    else $error("match right after counter write");
  chk_async_delay: assert property (async_sel_r && match_a ##1 async_sel_r [*2] |=> cmp_a_event)
    else $error("async compare event not after three cycles");
  chk_sync_event: assert property (!async_sel_r && match_b |=> cmp_b_event)
    else $error("sync compare event missing");
  chk_force_no_event: assert property (force_a && !match_a && !async_sel_r |=> !cmp_a_event)
    else $error("forced compare raised event");
  chk_osc_buffer: assert property (ext_clk_r && async_sel_r ##1 $stable(ext_clk_r) |-> osc_buf_enable)
    else $error("oscillator buffer not enabled");

  cov_async_load: cover property (async_sel_r && buf_wr[BUF_CMP_B] ##[1:100] !buf_busy[BUF_CMP_B]);
  cov_force_a: cover property (force_a);
  cov_overflow: cover property (ovf_event);
  cov_phase_turn: cover property (phase && tick && down_r);
endmodule : atr_timer

/* File: testbench/atr_timer_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) check_val(nm, 32'(ex), 32'(gt))
module atr_timer_bench import atr_pkg::*; ;
  logic pclk, presetn, clk_en, psel, penable, pwrite, osc_on;
  logic osc_input_pin = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, wave_out_chan_a, wave_out_chan_b, cmp_a_event, cmp_b_event, ovf_event;
  logic osc_buf_enable, xtal_osc_run;
  int error_cnt = 0, check_count = 0, cyc = 0, ev_a = 0, ev_b = 0, ev_o = 0, osc_rises = 0, osc_div = 0;
  logic [7:0] ofs [6] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_COUNT, OFS_CMP_A, OFS_CMP_B, OFS_ASTAT};

  atr_timer i_atr_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_input_pin(osc_input_pin), .wave_out_chan_a(wave_out_chan_a), .wave_out_chan_b(wave_out_chan_b),
    .cmp_a_event(cmp_a_event), .cmp_b_event(cmp_b_event), .ovf_event(ovf_event),
    .osc_buf_enable(osc_buf_enable), .xtal_osc_run(xtal_osc_run));

  // 100 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Slow oscillator pin, 16 bus cycles a period, and event tallies
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (osc_on) begin
      osc_div <= osc_div + 1;
      if (osc_div % 8 == 7) osc_input_pin <= ~osc_input_pin;
      if (osc_div % 8 == 7 && !osc_input_pin) osc_rises <= osc_rises + 1;
    end
    if (cmp_a_event === 1'b1) ev_a <= ev_a + 1;
    if (cmp_b_event === 1'b1) ev_b <= ev_b + 1;
    if (ovf_event === 1'b1) ev_o <= ev_o + 1;
  end

  task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    check_count++;
    if (gt !== ex) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, ex, gt);
    end
  endtask : check_val

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // One APB transfer; waits for pready as long as it takes, the watchdog ends a dead wait
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    if (n >= 50) `CHK("pready", 1'b1, 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic e;
    apb(a, 1'b0, 8'h00, q, e);
  endtask : rd

  // Division ratio of each clock select code; zero means stopped
  function automatic int div_of(input int c);
    case (c)
      1: return 1;
      2: return 8;
      3: return 32;
      4: return 64;
      5: return 128;
      6: return 256;
      7: return 1024;
      default: return 0;
    endcase
  endfunction : div_of

  // Watchdog; the full sequence needs roughly 6k cycles
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    logic [7:0] v, r, ra, rb, c0, c1, dl;
    logic e;
    int t0, ex, tol, a0, b0, o0, n;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    osc_on = 1'b0;
    void'($urandom(86));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state of every register and of the crystal enable
    `CHK("xtal_run_reset", 1'b1, xtal_osc_run);
    foreach (ofs[i]) begin
      rd(ofs[i], v);
      `CHK("reset_value", 8'h00, v);
    end
    apb(8'h18, 1'b0, 8'h00, v, e);
    `CHK("unmapped_err", 1'b1, e);
    // Random control B values: strobes and reserved bits never read back
    repeat (4) begin
      r = 8'($urandom);
      wr(OFS_CTRL_B, r);
      rd(OFS_CTRL_B, v);
      `CHK("ctrl_b_read", r & 8'h0F, v);
    end
    // Sync writes land directly, busy flags stay clear
    wr(OFS_CTRL_B, 8'h00);
    repeat (3) begin
      ra = 8'($urandom);
      rb = 8'($urandom);
      r = 8'($urandom);
      wr(OFS_CMP_A, ra);
      wr(OFS_CMP_B, rb);
      wr(OFS_COUNT, r);
      rd(OFS_CMP_A, v);
      `CHK("cmp_a_read", ra, v);
      rd(OFS_CMP_B, v);
      `CHK("cmp_b_read", rb, v);
      rd(OFS_COUNT, v);
      `CHK("count_read", r, v);
      rd(OFS_ASTAT, v);
      `CHK("sync_busy", 8'h00, v);
    end
    // Every clock select code, including stop, measured over a span of cycles
    wr(OFS_CTRL_A, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CTRL_B, 8'(c));
      rd(OFS_COUNT, c0);
      t0 = cyc;
      repeat (3 * div_of(c) + 4) @(posedge pclk);
      rd(OFS_COUNT, c1);
      dl = c1 - c0;
      ex = (c == 0) ? 0 : (cyc - t0) / div_of(c);
      tol = (c == 0) ? 0 : 1;
      `CHK("tick_rate", 1'b1, (int'(dl) >= ex - tol && int'(dl) <= ex + tol));
    end
    // Continuous compare on both channels plus overflow, free-running at full rate
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, 8'h50);
    wr(OFS_COUNT, 8'h00);
    a0 = ev_a;
    b0 = ev_b;
    o0 = ev_o;
    wr(OFS_CTRL_B, 8'h01);
    repeat (600) @(posedge pclk);
    `CHK("cmp_a_matches", 1'b1, (ev_a - a0 >= 2 && ev_a - a0 <= 3));
    `CHK("cmp_b_matches", 1'b1, (ev_b - b0 >= 2 && ev_b - b0 <= 3));
    `CHK("ovf_count", 1'b1, (ev_o - o0 >= 2 && ev_o - o0 <= 3));
    // Counter write equal to compare A while running: that match is dropped
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_COUNT, ra + 8'h80);
    wr(OFS_CTRL_B, 8'h01);
    a0 = ev_a;
    wr(OFS_COUNT, ra);
    repeat (60) @(posedge pclk);
    `CHK("blocked_match", a0, ev_a);
    // Force strobes in CTC mode with the counter stopped
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_COUNT, 8'h55);
    wr(OFS_CTRL_A, 8'hD2);
    a0 = ev_a;
    b0 = ev_b;
    e = wave_out_chan_b;
    wr(OFS_CTRL_B, 8'hC0);
    repeat (3) @(posedge pclk);
    `CHK("force_set_a", 1'b1, wave_out_chan_a);
    `CHK("force_toggle_b", !e, wave_out_chan_b);
    `CHK("force_no_event_a", a0, ev_a);
    `CHK("force_no_event_b", b0, ev_b);
    rd(OFS_COUNT, v);
    `CHK("force_no_clear", 8'h55, v);
    rd(OFS_CTRL_B, v);
    `CHK("force_reads_zero", 8'h00, v);
    wr(OFS_CTRL_A, 8'h82);
    wr(OFS_CTRL_B, 8'h80);
    repeat (3) @(posedge pclk);
    `CHK("force_clear_a", 1'b0, wave_out_chan_a);
    // External clock bit first, then async select; oscillator held still
    wr(OFS_ASTAT, 8'h40);
    repeat (2) @(posedge pclk);
    `CHK("xtal_stopped", 1'b0, xtal_osc_run);
    `CHK("buf_sync_off", 1'b0, osc_buf_enable);
    wr(OFS_ASTAT, 8'h60);
    repeat (2) @(posedge pclk);
    `CHK("buf_enabled", 1'b1, osc_buf_enable);
    // Writes to all five buffered registers set all five busy flags
    ra = 8'($urandom);
    wr(OFS_CMP_A, ra);
    wr(OFS_CMP_B, 8'($urandom));
    wr(OFS_COUNT, 8'($urandom));
    wr(OFS_CTRL_A, 8'($urandom) & 8'hF3);
    wr(OFS_CTRL_B, 8'($urandom) & 8'h0F);
    rd(OFS_ASTAT, v);
    `CHK("all_busy", 8'h7F, v);
    rd(OFS_CMP_A, v);
    `CHK("temp_read", ra, v);
    // Start the oscillator; busy clears after two pin rises
    osc_on <= 1'b1;
    n = 0;
    do begin
      rd(OFS_ASTAT, v);
      n++;
    end while (v !== 8'h60 && n < 40);
    `CHK("busy_cleared", 8'h60, v);
    `CHK("load_after_two", 1'b1, (osc_rises >= 2 && osc_rises <= 3));
    // Async compare at count 3; older matches drain before the tally is taken
    wr(OFS_CMP_A, 8'h03);
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_B, 8'h01);
    n = 0;
    do begin
      rd(OFS_ASTAT, v);
      n++;
    end while (v !== 8'h60 && n < 40);
    `CHK("async_idle", 8'h60, v);
    repeat (8) @(posedge pclk);
    a0 = ev_a;
    repeat (200) @(posedge pclk);
    `CHK("async_match", a0 + 1, ev_a);
    // Back to the bus clock
    osc_on <= 1'b0;
    wr(OFS_ASTAT, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("xtal_running", 1'b1, xtal_osc_run);
    `CHK("buf_disabled", 1'b0, osc_buf_enable);
    report_and_stop;
  end
endmodule : atr_timer_bench
